/* File: pkg/qdac_consts.svh */
`ifndef QDAC_CONSTS_SVH
`define QDAC_CONSTS_SVH

// Serial word layout, first bit shifted in ends up in the top bit
`define QDAC_WORD_BITS 16
`define QDAC_CODE_BITS 12
`define QDAC_NUM_CHAN 4
`define QDAC_ADDR_MSB 15
`define QDAC_ADDR_LSB 14
`define QDAC_CODE_MSB 11

// Reset codes
`define QDAC_CODE_ZERO 12'h000
`define QDAC_CODE_MID 12'h800

// Straight binary full-scale divisor
`define QDAC_FULL_SCALE 4096

// Synchroniser idle level for the pin group
`define QDAC_PIN_IDLE 7'h7f

// Combined shift clock idle level
`define QDAC_COMB_IDLE 1'b1

`endif

/* File: pkg/qdac_pkg.sv */
package qdac_pkg;

    typedef logic [11:0] qdac_code_t;

    typedef enum logic [1:0] {
        QDAC_CH_A = 2'b00,
        QDAC_CH_B = 2'b01,
        QDAC_CH_C = 2'b10,
        QDAC_CH_D = 2'b11
    } qdac_chan_t;

endpackage

/* File: logic/qdac_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module qdac_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pins in, synchronised out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // Two flops before any logic sees a pin
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stage1 <= INIT;
            sync_out <= INIT;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

`default_nettype wire

/* File: logic/qdac_serial_load.sv */
// Notes on behaviour
// - Shift clock is chip select OR serial clock
// - Chip select and serial clock are interchangeable
// - Chip select rising with clock low shifts once
// - Load low while shifting writes each passing address
// - Reset pin leaves shift register untouched
// - Input registers load without touching output registers
// - Output load falling edge copies all four channels
// - Output load held low makes outputs transparent
// - Channel codes are unsigned straight binary
// - Word: two address, two unused, twelve code bits
// - Reset pin sets zero or mid-scale code
// - Latched registers keep reset code after release
`timescale 1ns/100ps
`default_nettype none
`include "qdac_consts.svh"

module qdac_serial_load
    import qdac_pkg::*;
#(
    parameter int NCH = `QDAC_NUM_CHAN,
    parameter int CW = `QDAC_CODE_BITS,
    parameter int WW = `QDAC_WORD_BITS
) (
    // System clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial pins
    input wire logic chip_sel_n,
    input wire logic serial_clk,
    input wire logic serial_in,
    // Load strobes and reset pins
    input wire logic input_reg_load_n,
    input wire logic output_reg_load_n,
    input wire logic clear_n,
    input wire logic reset_code_select,
    // Converter codes, channel 0 in the low bits
    output logic [NCH*CW-1:0] chan_code,
    // Shift register contents
    output logic [WW-1:0] shift_word
);

    logic [6:0] pins_raw;
    logic [6:0] pins_s;
    logic s_cs_n;
    logic s_sclk;
    logic s_din;
    logic s_load_n;
    logic s_output_reg_load_n_n;
    logic s_clr_n;
    logic s_rsel;
    logic comb_prev;
    logic [NCH*CW-1:0] in_reg;

    wire comb_clk;
    wire shift_edge;
    wire [1:0] addr;
    wire load_in;
    wire load_out;
    wire qdac_code_t rst_code;
    wire [WW-1:0] next_shift;
    wire [NCH*CW-1:0] next_in;
    wire [NCH*CW-1:0] next_out;

    assign pins_raw = {chip_sel_n, serial_clk, serial_in, input_reg_load_n,
                       output_reg_load_n, clear_n, reset_code_select};

    qdac_sync #(
        .WIDTH(7),
        .INIT(`QDAC_PIN_IDLE)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    assign {s_cs_n, s_sclk, s_din, s_load_n, s_output_reg_load_n_n, s_clr_n, s_rsel} = pins_s;

    // Combined shift clock and its rising edge
    assign comb_clk = s_cs_n | s_sclk;
    assign shift_edge = comb_clk & ~comb_prev;
    assign next_shift = shift_edge ? {shift_word[WW-2:0], s_din} : shift_word;

    // Address in the top two bits, code in the low twelve
    assign addr = shift_word[`QDAC_ADDR_MSB:`QDAC_ADDR_LSB];
    assign load_in = ~s_load_n;
    assign load_out = ~s_output_reg_load_n_n;
    assign rst_code = s_rsel ? `QDAC_CODE_MID : `QDAC_CODE_ZERO;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_chan
            wire hit;
            assign hit = load_in && (addr == 2'(g));
            assign next_in[g*CW +: CW] = !s_clr_n ? rst_code :
                hit ? shift_word[`QDAC_CODE_MSB:0] : in_reg[g*CW +: CW];
            assign next_out[g*CW +: CW] = !s_clr_n ? rst_code :
                load_out ? in_reg[g*CW +: CW] : chan_code[g*CW +: CW];
        end
    endgenerate

    // Comb clock idles high so reset release makes no edge
    always_ff @(posedge clk) begin
        if (!resetn) begin
            comb_prev <= `QDAC_COMB_IDLE;
            shift_word <= '0;
        end else begin
            comb_prev <= comb_clk;
            shift_word <= next_shift;
        end
    end

    // Codes leave as unsigned straight binary
    always_ff @(posedge clk) begin
        if (!resetn) begin
            in_reg <= {NCH{`QDAC_CODE_ZERO}};
            chan_code <= {NCH{`QDAC_CODE_ZERO}};
        end else begin
            in_reg <= next_in;
            chan_code <= next_out;
        end
    end

    // Checks
    sequence s_output_reg_load_n_fall;
        s_output_reg_load_n_n ##1 (!s_output_reg_load_n_n && s_clr_n);
    endsequence

    sequence s_output_reg_load_n_held;
        (!s_output_reg_load_n_n && s_clr_n) [*2];
    endsequence

    property p_shift_advance;
        @(posedge clk) disable iff (!resetn)
        shift_edge |=> shift_word == {$past(shift_word[WW-2:0]), $past(s_din)};
    endproperty
    a_shift_advance: assert property (p_shift_advance)
        else $error("shift register did not advance on combined clock edge");

    property p_shift_idle;
        @(posedge clk) disable iff (!resetn)
        !shift_edge |=> $stable(shift_word);
    endproperty
    a_shift_idle: assert property (p_shift_idle)
        else $error("shift register moved without a clock edge");

    property p_clk_only;
        @(posedge clk) disable iff (!resetn)
        ($rose(s_sclk) && !s_cs_n && !$past(s_cs_n)) |-> shift_edge;
    endproperty
    a_clk_only: assert property (p_clk_only)
        else $error("serial clock rise under chip select gave no shift");

    property p_cs_extra;
        @(posedge clk) disable iff (!resetn)
        ($rose(s_cs_n) && !s_sclk && !$past(s_sclk)) |-> shift_edge;
    endproperty
    a_cs_extra: assert property (p_cs_extra)
        else $error("chip select rise with clock low gave no shift");

    property p_clear_keeps_shift;
        @(posedge clk) disable iff (!resetn)
        (!s_clr_n && comb_clk && comb_prev) |=> $stable(shift_word);
    endproperty
    a_clear_keeps_shift: assert property (p_clear_keeps_shift)
        else $error("reset pin disturbed the shift register");

    property p_input_load;
        @(posedge clk) disable iff (!resetn)
        (!s_load_n && s_clr_n) |=>
            in_reg[$past(addr)*CW +: CW] == $past(shift_word[`QDAC_CODE_MSB:0]);
    endproperty
    a_input_load: assert property (p_input_load)
        else $error("addressed input register missed the shifted code");

    property p_out_hold;
        @(posedge clk) disable iff (!resetn)
        (s_output_reg_load_n_n && s_clr_n) |=> $stable(chan_code);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("converter code changed while output load high");

    property p_in_hold;
        @(posedge clk) disable iff (!resetn)
        (s_load_n && s_clr_n) |=> $stable(in_reg);
    endproperty
    a_in_hold: assert property (p_in_hold)
        else $error("input register changed while input load high");

    property p_output_reg_load_n_fall;
        @(posedge clk) disable iff (!resetn)
        s_output_reg_load_n_fall |=> chan_code == $past(in_reg);
    endproperty
    a_output_reg_load_n_fall: assert property (p_output_reg_load_n_fall)
        else $error("output load fall did not copy all channels");

    property p_transparent;
        @(posedge clk) disable iff (!resetn)
        s_output_reg_load_n_held |=> chan_code == $past(in_reg);
    endproperty
    a_transparent: assert property (p_transparent)
        else $error("converter codes not following input registers");

    property p_reset_code;
        @(posedge clk) disable iff (!resetn)
        !s_clr_n |=> (in_reg == {NCH{$past(rst_code)}}) && (chan_code == {NCH{$past(rst_code)}});
    endproperty
    a_reset_code: assert property (p_reset_code)
        else $error("reset pin did not set the selected code");

    property p_retain;
        @(posedge clk) disable iff (!resetn)
        ($rose(s_clr_n) && s_load_n && s_output_reg_load_n_n) |=> $stable(chan_code) ##1 $stable(chan_code);
    endproperty
    a_retain: assert property (p_retain)
        else $error("latched codes lost after reset release");

endmodule

`default_nettype wire

/* File: verification/qdac_host.sv */
`timescale 1ns/100ps
`default_nettype none

module qdac_host (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic chip_sel_n,
    output logic serial_clk,
    output logic serial_in
);
    initial begin
        chip_sel_n = 1'b1;
        serial_clk = 1'b1;
        serial_in = 1'b0;
    end

    task automatic half();
        repeat (4) @(negedge clk);
    endtask

    // Mode 0 both pins, 1 chip select only, 2 chip select rises with clock low
    task automatic send(input logic [15:0] w, input int mode);
        serial_clk = (mode == 1) ? 1'b0 : 1'b1;
        half();
        for (int i = 15; i >= 0; i--) begin
            serial_in = w[i];
            chip_sel_n = 1'b0;
            if (mode != 1) serial_clk = 1'b0;
            half();
            if (mode == 1) chip_sel_n = 1'b1;
            else serial_clk = 1'b1;
            half();
        end
        if (mode == 2) begin
            serial_in = 1'b1;
            serial_clk = 1'b0;
            half();
            // Chip select rises alone while clock is low
            chip_sel_n = 1'b1;
            half();
        end
        chip_sel_n = 1'b1;
        serial_clk = 1'b1;
        half();
        // Released data line shows the inverse
        serial_in = ~serial_in;
    endtask
endmodule

`default_nettype wire

/* File: verification/quad_dac_serial_load_control_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module quad_dac_serial_load_control_bench
    import qdac_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic input_reg_load_n = 1'b1;
    logic output_reg_load_n = 1'b1;
    logic clear_n = 1'b1;
    logic reset_code_select = 1'b0;
    wire logic chip_sel_n;
    wire logic serial_clk;
    wire logic serial_in;
    logic [47:0] chan_code;
    logic [15:0] shift_word;
    int errors = 0;
    int checks = 0;
    logic [15:0] flow_word;
    logic [15:0] flow_in = 16'h36c1;
    qdac_code_t in_exp [4];
    qdac_code_t out_exp [4];
    qdac_code_t tab [4] = '{12'h001, 12'h7ff, 12'hffe, 12'h9c3};

    always #20 clk = ~clk;

    qdac_host i_qdac_host (.clk(clk), .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
        .serial_in(serial_in));

    qdac_serial_load i_qdac_serial_load (.clk(clk), .resetn(resetn),
        .chip_sel_n(chip_sel_n), .serial_clk(serial_clk), .serial_in(serial_in),
        .input_reg_load_n(input_reg_load_n), .output_reg_load_n(output_reg_load_n),
        .clear_n(clear_n), .reset_code_select(reset_code_select),
        .chan_code(chan_code), .shift_word(shift_word));

    task automatic end_sim();
        if (errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] want);
        checks++;
        if (seen !== want) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check_out();
        check("chan_code", chan_code, {out_exp[3], out_exp[2], out_exp[1], out_exp[0]});
    endtask

    task automatic clear_all(input logic sel);
        reset_code_select = sel;
        cyc(2);
        clear_n = 1'b0;
        cyc(4);
        clear_n = 1'b1;
        cyc(6);
        for (int i = 0; i < 4; i++) begin
            in_exp[i] = sel ? 12'h800 : 12'h000;
            out_exp[i] = in_exp[i];
        end
    endtask

    task automatic write_chan(input int ch, input qdac_code_t code, input int mode);
        i_qdac_host.send({ch[1:0], 2'b10, code}, mode);
        cyc(4);
        check("shift_word", {32'h0, shift_word}, {32'h0, ch[1:0], 2'b10, code});
        input_reg_load_n = 1'b0;
        cyc(4);
        input_reg_load_n = 1'b1;
        cyc(6);
        in_exp[ch] = code;
        if (output_reg_load_n == 1'b0) out_exp[ch] = code;
    endtask

    initial begin
        for (int i = 0; i < 4; i++) out_exp[i] = 12'h000;
        cyc(20);
        resetn = 1'b1;
        cyc(2);
        check_out();
        check("shift_word", {32'h0, shift_word}, 48'h0);
        clear_all(1'b1);
        check_out();
        for (int i = 0; i < 4; i++) write_chan(i, tab[i], i % 2);
        check_out();
        output_reg_load_n = 1'b0;
        cyc(4);
        output_reg_load_n = 1'b1;
        cyc(6);
        out_exp = in_exp;
        check_out();
        output_reg_load_n = 1'b0;
        cyc(6);
        write_chan(2, 12'h5a5, 0);
        check_out();
        output_reg_load_n = 1'b1;
        cyc(4);
        i_qdac_host.send(16'h4abc, 2);
        cyc(4);
        check("shift_word", {32'h0, shift_word}, 48'h9579);
        clear_all(1'b0);
        check("shift_word", {32'h0, shift_word}, 48'h9579);
        check_out();
        // Shift with both loads low: every register passed over is written
        output_reg_load_n = 1'b0;
        input_reg_load_n = 1'b0;
        cyc(4);
        i_qdac_host.send(flow_in, 0);
        cyc(4);
        input_reg_load_n = 1'b1;
        cyc(6);
        flow_word = 16'h9579;
        for (int n = 0; n <= 16; n++) begin
            out_exp[flow_word[15:14]] = flow_word[11:0];
            if (n < 16) flow_word = {flow_word[14:0], flow_in[15 - n]};
        end
        check_out();
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        end_sim();
    end
endmodule

`default_nettype wire
